/* File: verilog/crs_defs.svh */
// Register offsets, field positions, reset values and boot addresses of the reset block.
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_ADDR_W        8
`define CRS_OFF_CTRL      8'h00
`define CRS_OFF_CACHE     8'h04
`define CRS_OFF_DEBUG     8'h08
`define CRS_OFF_PEND      8'h0C
`define CRS_OFF_COUNT     8'h10
`define CRS_OFF_COMPARE   8'h14
`define CRS_OFF_ISTAT     8'h18
`define CRS_OFF_IMASK     8'h1C
`define CRS_CTRL_ERL      0
`define CRS_CTRL_EXL      1
`define CRS_CTRL_BEV      2
`define CRS_CTRL_SR       3
`define CRS_CTRL_TS       4
`define CRS_CTRL_NMI      5
`define CRS_CTRL_RP       6
`define CRS_CTRL_RST      7'h0D
`define CRS_CACHE_UNCACHED 3'h2
`define CRS_CACHE_RST     9'h092
`define CRS_DBG_DM        0
`define CRS_DBG_RST       5'h00
`define CRS_PEND_WATCH    0
`define CRS_PEND_SW_LO    1
`define CRS_IRQ_TIMER     0
`define CRS_IRQ_SOFTRST   1
`define CRS_IRQ_WDT       2
`define CRS_BOOT_VA       32'hBFC00000
`define CRS_BOOT_PA       32'h1FC00000
`endif

/* File: verilog/crs_pkg.sv */
// Types shared by the reset block modules.
package crs_pkg;
  typedef enum logic [2:0] {
    CRS_ST_RESET = 3'h1,
    CRS_ST_FETCH = 3'h2,
    CRS_ST_RUN   = 3'h4
  } crs_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } crs_sync_t;

  typedef struct packed {
    logic [31:0] count;
    logic [31:0] compare;
    logic        match;
  } crs_tmr_t;
endpackage

/* File: verilog/crs_sync2.sv */
// Two flip-flop synchroniser for a single level.
`timescale 1ns/1ps
`default_nettype none
module crs_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk,   // core clock
  input  wire logic i_rst_b, // async reset, active low
  input  wire logic i_async, // level from outside the domain
  output logic      o_sync   // synchronised level
);
  crs_pkg::crs_sync_t q;
  crs_pkg::crs_sync_t d;

  always_comb begin
    d    = q;
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;
endmodule // crs_sync2
`default_nettype wire

/* File: verilog/crs_timer.sv */
// Tick counter and tick match register with a one-cycle match pulse.
`timescale 1ns/1ps
`default_nettype none
module crs_timer (
  input  wire logic        i_clk,    // core clock
  input  wire logic        i_rst_b,  // async reset, active low
  input  wire logic        i_cnt_we, // load the tick counter
  input  wire logic        i_cmp_we, // load the tick match value
  input  wire logic [31:0] i_wdata,  // load value
  output logic      [31:0] o_count,  // tick counter
  output logic      [31:0] o_compare,// tick match value
  output logic             o_match   // pulse, counter equals match
);
  crs_pkg::crs_tmr_t q;
  crs_pkg::crs_tmr_t d;

  // The counter and match value are left untouched by soft resets on
  // purpose: firmware owns them and reloads them before use.
  always_comb begin
    d         = q;
    d.count   = q.count + 32'h00000001;
    if (i_cnt_we) begin
      d.count = i_wdata;
    end
    if (i_cmp_we) begin
      d.compare = i_wdata;
    end
    d.match   = (d.count == d.compare) && !i_cmp_we; // RL5
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{count: 32'h00000000, compare: 32'hFFFFFFFF, match: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_count   = q.count;
  assign o_compare = q.compare;
  assign o_match   = q.match;
endmodule // crs_timer
`default_nettype wire

/* File: verilog/crs_top.sv */
// Core reset and initialisation logic with tick timer and register port.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "crs_defs.svh"
`default_nettype none
// Rules from the document
// RL1 - General register zero always reads back as zero.
// RL2 - Watch and soft requests survive reset; blocked while either level flag is set; here only soft reset keeps them, power-up clears them.
// RL3 - Firmware clears watch and soft requests before leaving boot code.
// RL4 - Firmware programs the three cache modes; they reset to uncached 010.
// RL5 - Timer interrupt raised when tick counter equals tick match value.
// RL6 - Any write to tick match clears a pending timer interrupt; here a tick match pulse in the same cycle keeps it set.
// RL7 - A mask bit keeps the timer interrupt from the processor.
// RL8 - Firmware loads the tick counter before the tick match value.
// RL9 - Firmware writes registers before reading; masks bits it never set.
// RL10 - Firmware sets up the bus matrix before user mode or data RAM execution.
// RL11 - Reset sets only the minimal state to run unmapped uncached code.
// RL12 - Asserting the external clear pin forces a soft reset.
// RL13 - Soft reset is handled exactly like power-up reset; here it keeps pending requests, masks and timer, which power-up clears.
// RL14 - Reset sets boot vector, soft reset, error level; clears shutdown, NMI, power.
// RL15 - Reset clears debug bits; debug mode follows the debug boot option.
// RL16 - Reset aborts every bus transaction and resets the memory state machines.
// RL17 - First fetch goes to the boot vector unless booting into debug.
// RL18 - Watchdog timeout outside sleep forces the reset values.
// RL19 - Reset values apply on the clock; first fetch in cycle after release. After power-up the clear pin hold delays the first fetch by two more cycles.
module crs_top #(
  parameter logic [31:0] DBG_BOOT_VA = 32'h00000000
) (
  input  wire logic        i_clk,         // core clock, 25 MHz
  input  wire logic        i_rst_b,       // power-up reset, active low
  input  wire logic        i_clear_pin_b, // external clear pin, active low
  input  wire logic        i_debug_boot,  // debug boot strap pin
  input  wire logic [7:0]  i_cfg_static,  // static configuration inputs
  input  wire logic        i_wdt_timeout, // watchdog timeout pulse
  input  wire logic        i_sleep,       // core is in sleep
  input  wire logic        i_watch_hit,   // watch point hit pulse
  input  wire logic [4:0]  i_gpr_sel,     // general register index
  input  wire logic [31:0] i_gpr_data,    // raw register file data
  input  wire logic [7:0]  i_addr,        // register address
  input  wire logic [31:0] i_wdata,       // register write data
  input  wire logic        i_we,          // register write strobe
  input  wire logic        i_re,          // register read strobe
  output logic      [31:0] o_rdata,       // register read data
  output logic      [31:0] o_gpr_rdata,   // general register read data
  output logic             o_bus_abort,   // hold bus and memory in reset
  output logic             o_fetch_req,   // first fetch request pulse
  output logic      [31:0] o_fetch_addr,  // first fetch virtual address
  output logic             o_watch_exc,   // watch exception request
  output logic      [1:0]  o_swint_exc,   // soft interrupt requests
  output logic             o_debug_mode,  // debug mode flag
  output logic             o_irq          // unmasked interrupt level
);
  typedef struct packed {
    crs_pkg::crs_state_t st;
    logic [6:0]  ctrl;
    logic [8:0]  cache;
    logic [7:0]  cfg_in;
    logic [4:0]  dbg;
    logic [2:0]  pend;
    logic [2:0]  istat;
    logic [2:0]  imask;
    logic [31:0] rdata;
    logic [31:0] gpr;
    logic        abort;
    logic        fetch;
    logic [31:0] faddr;
    logic        watch;
    logic [1:0]  swint;
    logic        irq;
  } crs_top_t;

  crs_top_t q;
  crs_top_t d;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic        pin_b_s;
  logic        dbg_boot_s;
  logic        soft_rst;
  logic        wdt_rst;
  logic        cnt_we;
  logic        cmp_we;
  logic        tmr_match;
  logic [31:0] tmr_count;
  logic [31:0] tmr_compare;

  // The clear pin leaves reset reading low, which holds the core two more
  // cycles so that the debug strap has passed its synchroniser before use.
  crs_sync2 #(.RST_VAL(1'b0)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_clear_pin_b),
    .o_sync  (pin_b_s)
  );

  crs_sync2 #(.RST_VAL(1'b0)) u_dbg_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_debug_boot),
    .o_sync  (dbg_boot_s)
  );

  assign cnt_we = i_we && (i_addr == `CRS_OFF_COUNT);
  assign cmp_we = i_we && (i_addr == `CRS_OFF_COMPARE);

  crs_timer u_timer (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_cnt_we  (cnt_we),
    .i_cmp_we  (cmp_we),
    .i_wdata   (i_wdata),
    .o_count   (tmr_count),
    .o_compare (tmr_compare),
    .o_match   (tmr_match)
  );

  // A watchdog timeout during sleep wakes the core instead; not handled here.
  assign wdt_rst  = i_wdt_timeout && !i_sleep; // RL18
  assign soft_rst = !pin_b_s || wdt_rst; // RL12

  always_comb begin
    d       = q;
    d.fetch = 1'b0;
    d.rdata = 32'h00000000;
    // Register index zero is forced here so the file itself needs no reset.
    d.gpr   = (i_gpr_sel == 5'h00) ? 32'h00000000 : i_gpr_data; // RL1

    if (i_we) begin
      unique case (i_addr)
        `CRS_OFF_CTRL: begin
          d.ctrl[`CRS_CTRL_ERL] = i_wdata[`CRS_CTRL_ERL];
          d.ctrl[`CRS_CTRL_EXL] = i_wdata[`CRS_CTRL_EXL];
          d.ctrl[`CRS_CTRL_BEV] = i_wdata[`CRS_CTRL_BEV];
          d.ctrl[`CRS_CTRL_SR]  = i_wdata[`CRS_CTRL_SR];
          d.ctrl[`CRS_CTRL_NMI] = i_wdata[`CRS_CTRL_NMI];
          d.ctrl[`CRS_CTRL_RP]  = i_wdata[`CRS_CTRL_RP];
        end
        `CRS_OFF_CACHE: d.cache = i_wdata[8:0];
        `CRS_OFF_DEBUG: d.dbg   = i_wdata[4:0];
        `CRS_OFF_PEND:  d.pend  = i_wdata[2:0];
        `CRS_OFF_ISTAT: d.istat = q.istat & ~i_wdata[2:0];
        `CRS_OFF_IMASK: d.imask = i_wdata[2:0];
        default: ;
      endcase
    end
    if (cmp_we) begin
      d.istat[`CRS_IRQ_TIMER] = 1'b0; // RL6
    end

    // Hardware sets are applied after software clears so they win.
    if (tmr_match) begin
      d.istat[`CRS_IRQ_TIMER] = 1'b1; // RL5
    end
    if (i_watch_hit) begin
      d.pend[`CRS_PEND_WATCH] = 1'b1;
    end

    if (i_re) begin
      unique case (i_addr)
        `CRS_OFF_CTRL:    d.rdata = {25'h0000000, q.ctrl};
        `CRS_OFF_CACHE:   d.rdata = {8'h00, q.cfg_in, 7'h00, q.cache};
        `CRS_OFF_DEBUG:   d.rdata = {27'h0000000, q.dbg};
        `CRS_OFF_PEND:    d.rdata = {29'h00000000, q.pend};
        `CRS_OFF_COUNT:   d.rdata = tmr_count;
        `CRS_OFF_COMPARE: d.rdata = tmr_compare;
        `CRS_OFF_ISTAT:   d.rdata = {29'h00000000, q.istat};
        `CRS_OFF_IMASK:   d.rdata = {29'h00000000, q.imask};
        default:          d.rdata = 32'h00000000;
      endcase
    end

    unique case (q.st)
      crs_pkg::CRS_ST_RESET: begin
        d.st    = crs_pkg::CRS_ST_FETCH;
        d.fetch = 1'b1; // RL19
        d.faddr = q.dbg[`CRS_DBG_DM] ? DBG_BOOT_VA : `CRS_BOOT_VA; // RL17
      end
      crs_pkg::CRS_ST_FETCH: d.st = crs_pkg::CRS_ST_RUN;
      crs_pkg::CRS_ST_RUN:   d.st = crs_pkg::CRS_ST_RUN;
      default:               d.st = crs_pkg::CRS_ST_RESET;
    endcase

    // Soft reset takes the same path as power-up; only the minimal state is
    // touched, pending requests and the timer are left for firmware.
    if (soft_rst) begin // RL13
      d.st     = crs_pkg::CRS_ST_RESET;
      d.fetch  = 1'b0;
      d.ctrl   = `CRS_CTRL_RST; // RL14
      d.cache  = `CRS_CACHE_RST; // RL11
      d.cfg_in = i_cfg_static; // RL14
      d.dbg    = `CRS_DBG_RST; // RL15
      d.dbg[`CRS_DBG_DM] = dbg_boot_s; // RL15
      // The power-up hold also passes here; it is no soft reset event, so
      // the soft reset flag is not recorded while the core is still being held.
      if (!q.abort) begin
        d.istat[`CRS_IRQ_SOFTRST] = 1'b1;
      end
      if (wdt_rst) begin
        d.istat[`CRS_IRQ_WDT] = 1'b1;
      end
    end else if (q.st == crs_pkg::CRS_ST_RESET) begin
      d.cfg_in = i_cfg_static; // RL14
      d.dbg[`CRS_DBG_DM] = dbg_boot_s; // RL15
      d.faddr  = dbg_boot_s ? DBG_BOOT_VA : `CRS_BOOT_VA; // RL17
    end

    d.abort = (d.st == crs_pkg::CRS_ST_RESET); // RL16
    d.watch = d.pend[`CRS_PEND_WATCH] &&
              !d.ctrl[`CRS_CTRL_ERL] && !d.ctrl[`CRS_CTRL_EXL]; // RL2
    d.swint = (d.ctrl[`CRS_CTRL_ERL] || d.ctrl[`CRS_CTRL_EXL]) ?
              2'h0 : d.pend[2:1]; // RL2
    d.irq   = |(d.istat & d.imask); // RL7
  end

  // Pending requests come up clear only at power-up; soft resets keep them.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{st:     crs_pkg::CRS_ST_RESET,
             ctrl:   `CRS_CTRL_RST,
             cache:  `CRS_CACHE_RST,
             cfg_in: 8'h00,
             dbg:    `CRS_DBG_RST,
             pend:   3'h0,
             istat:  3'h0,
             imask:  3'h0,
             rdata:  32'h00000000,
             gpr:    32'h00000000,
             abort:  1'b1,
             fetch:  1'b0,
             faddr:  `CRS_BOOT_VA,
             watch:  1'b0,
             swint:  2'h0,
             irq:    1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_rdata      = q.rdata;
  assign o_gpr_rdata  = q.gpr;
  assign o_bus_abort  = q.abort;
  assign o_fetch_req  = q.fetch;
  assign o_fetch_addr = q.faddr;
  assign o_watch_exc  = q.watch;
  assign o_swint_exc  = q.swint;
  assign o_debug_mode = q.dbg[`CRS_DBG_DM];
  assign o_irq        = q.irq;

  AST_ZERO_REG: assert property ( // RL1
    (i_gpr_sel == 5'h00) |=> (o_gpr_rdata == 32'h00000000))
    else $error("register zero did not read as zero");

  AST_PEND_KEEP: assert property ( // RL2
    (soft_rst && q.pend[`CRS_PEND_WATCH] && !i_we) |=>
      q.pend[`CRS_PEND_WATCH])
    else $error("watch request lost across soft reset");

  AST_BLOCK: assert property ( // RL2
    (q.ctrl[`CRS_CTRL_ERL] || q.ctrl[`CRS_CTRL_EXL]) |->
      (!o_watch_exc && (o_swint_exc == 2'h0)))
    else $error("request passed while a level flag was set");

  AST_MATCH: assert property ( // RL5
    (tmr_match && q.imask[`CRS_IRQ_TIMER] && !i_we) |=> o_irq)
    else $error("tick match raised no interrupt");

  AST_CMP_CLR: assert property ( // RL6
    (cmp_we && !tmr_match) |=> !q.istat[`CRS_IRQ_TIMER])
    else $error("tick match write left timer pending");

  AST_MASK: assert property ( // RL7
    (!q.imask[`CRS_IRQ_TIMER] && (q.istat[2:1] == 2'h0) && !i_we &&
     !soft_rst) |=> !o_irq)
    else $error("masked timer reached the interrupt output");

  AST_PIN_RESET: assert property ( // RL12
    $fell(pin_b_s) |=> (o_bus_abort && !o_fetch_req))
    else $error("clear pin did not reset the core");

  AST_RESET_VALS: assert property ( // RL14
    soft_rst |=> ((q.ctrl == `CRS_CTRL_RST) &&
                  (q.cache == `CRS_CACHE_RST) &&
                  (q.dbg[4:1] == 4'h0)))
    else $error("reset values not applied");

  AST_FETCH: assert property ( // RL19
    (o_bus_abort && !soft_rst) |=>
      (o_fetch_req && !o_bus_abort &&
       (o_fetch_addr == (o_debug_mode ? DBG_BOOT_VA : `CRS_BOOT_VA))))
    else $error("first fetch not issued after reset release");

  AST_WDT: assert property ( // RL18
    (wdt_rst ##1 !soft_rst) |-> (o_bus_abort ##1 o_fetch_req))
    else $error("watchdog timeout did not reset the core");

  AST_WDT_SLEEP: assert property ( // RL18
    (i_wdt_timeout && i_sleep && pin_b_s && !o_bus_abort) |=>
      !o_bus_abort)
    else $error("watchdog timeout in sleep reset the core");

  AST_ABORT: assert property ( // RL16
    soft_rst |=> (o_bus_abort && !o_fetch_req))
    else $error("bus not aborted during reset");

  AST_FETCH_RISE: assert property ( // RL19
    $fell(o_bus_abort) |-> o_fetch_req)
    else $error("abort dropped without a first fetch");

  AST_FETCH_ONCE: assert property ( // RL19
    o_fetch_req |=> !o_fetch_req)
    else $error("first fetch request longer than one cycle");

  AST_BOOT_VA: assert property ( // RL17
    (o_fetch_req && !o_debug_mode) |-> (o_fetch_addr == `CRS_BOOT_VA))
    else $error("first fetch not at the boot vector");

  AST_DBG_VA: assert property ( // RL17
    (o_fetch_req && o_debug_mode) |-> (o_fetch_addr == DBG_BOOT_VA))
    else $error("debug boot fetch not at the debug vector");

  AST_DBG_BOOT: assert property ( // RL15
    soft_rst |=> (o_debug_mode == $past(dbg_boot_s)))
    else $error("debug mode does not follow the boot option");

  AST_CFG_LOAD: assert property ( // RL14
    soft_rst |=> (q.cfg_in == $past(i_cfg_static)))
    else $error("static configuration not loaded");

  AST_PEND_SOFT: assert property ( // RL2
    (soft_rst && !i_we && !i_watch_hit) |=> (q.pend == $past(q.pend)))
    else $error("pending requests changed across soft reset");

  AST_RESET_BLOCK: assert property ( // RL2
    soft_rst |=> (!o_watch_exc && (o_swint_exc == 2'h0)))
    else $error("request passed right after a reset");

  AST_TMR_KEEP: assert property ( // RL11
    (soft_rst && !cmp_we) |=> (tmr_compare == $past(tmr_compare)))
    else $error("soft reset touched the tick match value");
endmodule // crs_top
`default_nettype wire

/* File: dv/crs_ext_model.sv */
// Model of the external clear pin and the debug boot strap.
`timescale 1ns/1ps
`default_nettype none
module crs_ext_model (
  input  wire logic       i_clk,         // core clock
  input  wire logic       i_go,          // start one clear pulse
  input  wire logic [3:0] i_hold,        // pulse length in cycles
  input  wire logic       i_dbg,         // wanted strap level
  output logic            o_clear_pin_b, // clear pin, active low
  output logic            o_debug_boot   // debug boot strap level
);
  logic [3:0] left_q  = 4'h0;
  logic       clear_q = 1'b1;
  logic       strap_q = 1'b0;
  // Whole-cycle pulses, so the receiving synchroniser always sees a level.
  always @(posedge i_clk) begin
    if (i_go) begin
      left_q <= i_hold;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
    clear_q <= !(i_go || (left_q > 4'h1));
    strap_q <= i_dbg;
  end
  assign o_clear_pin_b = clear_q;
  assign o_debug_boot  = strap_q;
endmodule // crs_ext_model
`default_nettype wire

/* File: dv/cpu_core_reset_state_tb.sv */
// Self-checking bench for the core reset and tick timer block.
`timescale 1ns/1ps
`default_nettype none
`include "crs_defs.svh"
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
`define WAITFOR(c) \
  for (wk = 0; wk < 64 && (c) !== 1'b1; wk++) begin \
    @(posedge i_clk); \
    #1; \
  end \
  if ((c) !== 1'b1) timed_out();
module cpu_core_reset_state_tb;
  localparam logic [31:0] DBG_VA = 32'h00A5_5000;
  localparam logic [31:0] CTRL_RST = 32'((1 << `CRS_CTRL_ERL) |
    (1 << `CRS_CTRL_BEV) | (1 << `CRS_CTRL_SR));
  logic        i_clk, i_rst_b, i_we, i_re, i_sleep, i_wdt_timeout;
  logic        i_watch_hit, go, dbg, clr_b, dbg_pin;
  logic        o_bus_abort, o_fetch_req, o_watch_exc, o_debug_mode, o_irq;
  logic [1:0]  o_swint_exc;
  logic [3:0]  hold;
  logic [4:0]  i_gpr_sel;
  logic [7:0]  i_addr, i_cfg_static;
  logic [31:0] i_wdata, i_gpr_data, o_rdata, o_gpr_rdata, o_fetch_addr;
  logic [31:0] seed, base;
  int          mismatches, check_count, wk;

  crs_top #(.DBG_BOOT_VA(DBG_VA)) dut (.i_clk, .i_rst_b,
    .i_clear_pin_b(clr_b), .i_debug_boot(dbg_pin), .i_cfg_static,
    .i_wdt_timeout, .i_sleep, .i_watch_hit, .i_gpr_sel, .i_gpr_data,
    .i_addr, .i_wdata, .i_we, .i_re, .o_rdata, .o_gpr_rdata, .o_bus_abort,
    .o_fetch_req, .o_fetch_addr, .o_watch_exc, .o_swint_exc, .o_debug_mode,
    .o_irq);
  crs_ext_model ext (.i_clk, .i_go(go), .i_hold(hold), .i_dbg(dbg),
    .o_clear_pin_b(clr_b), .o_debug_boot(dbg_pin));

  initial i_clk = 1'b0;
  always #20 i_clk = ~i_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] exp_cache(input logic [7:0] cfg);
    return {8'h00, cfg, 7'h00, {3{`CRS_CACHE_UNCACHED}}};
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic timed_out();
    mismatches++;
    $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    `CHK(o_rdata & m, e)
  endtask
  task automatic fetch_chk(input logic [31:0] va);
    `WAITFOR(o_fetch_req)
    `CHK(o_fetch_addr, va)
    `CHK(o_bus_abort, 1'b0)
    @(posedge i_clk);
    #1;
    `CHK(o_fetch_req, 1'b0)
  endtask
  task automatic pin_reset(input logic [3:0] h, input logic [31:0] va);
    @(posedge i_clk);
    hold <= h;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    `WAITFOR(o_bus_abort)
    @(posedge i_clk);
    #1;
    `CHK(o_bus_abort, 1'b1)
    fetch_chk(va);
  endtask

  initial begin
    #3000000;
    timed_out();
  end

  initial begin
    seed = 32'h5359F1DD;
    mismatches = 0;
    check_count = 0;
    {i_rst_b, i_we, i_re, i_sleep, i_wdt_timeout, i_watch_hit} = 6'h00;
    {go, dbg, i_gpr_sel, i_addr} = 15'h0000;
    {i_wdata, i_gpr_data} = 64'h0;
    hold = 4'h6;
    i_cfg_static = 8'(rnd());
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    fetch_chk(`CRS_BOOT_VA);
    rd(`CRS_OFF_CTRL, 32'h7F, CTRL_RST);
    rd(`CRS_OFF_CACHE, 32'h00FF01FF, exp_cache(i_cfg_static));
    rd(`CRS_OFF_DEBUG, 32'h1F, 32'h0);
    rd(`CRS_OFF_PEND, 32'h7, 32'h0);
    `CHK(o_debug_mode, 1'b0)
    $display("test power_up done");
    // Bit 4 is read only; unmapped places read zero and swallow writes.
    wr(`CRS_OFF_CTRL, 32'h7F);
    rd(`CRS_OFF_CTRL, 32'h7F, 32'h6F);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'hFFFF_FFFF, 32'h0);
    for (int n = 0; n < 16; n++) begin
      @(posedge i_clk);
      i_gpr_sel <= (n % 4 == 0) ? 5'h00 : 5'(rnd());
      i_gpr_data <= rnd();
      @(posedge i_clk);
      #1;
      `CHK(o_gpr_rdata, (i_gpr_sel == 5'h00) ? 32'h0 : i_gpr_data)
    end
    $display("test registers done");
    base = rnd();
    wr(`CRS_OFF_IMASK, 32'h1);
    wr(`CRS_OFF_COUNT, base);
    wr(`CRS_OFF_COMPARE, base + 32'h00000028);
    `WAITFOR(o_irq)
    `CHK(wk > 30 && wk < 45, 1'b1)
    wr(`CRS_OFF_IMASK, 32'h0);
    rd(`CRS_OFF_ISTAT, 32'h1, 32'h1);
    `CHK(o_irq, 1'b0)
    wr(`CRS_OFF_COMPARE, 32'hFFFF_FFF0);
    rd(`CRS_OFF_ISTAT, 32'h1, 32'h0);
    $display("test timer done");
    wr(`CRS_OFF_PEND, 32'h6);
    @(posedge i_clk);
    i_watch_hit <= 1'b1;
    @(posedge i_clk);
    i_watch_hit <= 1'b0;
    wr(`CRS_OFF_CTRL, 32'h0C);
    rd(`CRS_OFF_PEND, 32'h7, 32'h7);
    `CHK({o_watch_exc, o_swint_exc}, 3'h7)
    wr(`CRS_OFF_CTRL, 32'h6E);
    rd(`CRS_OFF_PEND, 32'h7, 32'h7);
    `CHK({o_watch_exc, o_swint_exc}, 3'h0)
    wr(`CRS_OFF_DEBUG, 32'h1E);
    wr(`CRS_OFF_CACHE, 32'h1FF);
    i_cfg_static <= 8'(rnd());
    pin_reset(4'h6, `CRS_BOOT_VA);
    rd(`CRS_OFF_CTRL, 32'h7F, CTRL_RST);
    rd(`CRS_OFF_CACHE, 32'h00FF01FF, exp_cache(i_cfg_static));
    rd(`CRS_OFF_DEBUG, 32'h1F, 32'h0);
    rd(`CRS_OFF_PEND, 32'h7, 32'h7);
    rd(`CRS_OFF_ISTAT, 32'h2, 32'h2);
    `CHK({o_watch_exc, o_swint_exc}, 3'h0)
    wr(`CRS_OFF_PEND, 32'h0);
    wr(`CRS_OFF_CACHE, 32'h0DB);
    wr(`CRS_OFF_CTRL, 32'h0C);
    `CHK({o_watch_exc, o_swint_exc}, 3'h0)
    wr(`CRS_OFF_ISTAT, 32'h6);
    rd(`CRS_OFF_ISTAT, 32'h6, 32'h0);
    $display("test clear_pin done");
    // A timeout during sleep must leave the core running.
    @(posedge i_clk);
    i_sleep <= 1'b1;
    i_wdt_timeout <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_wdt_timeout <= 1'b0;
    #1;
    `CHK(o_bus_abort, 1'b0)
    rd(`CRS_OFF_ISTAT, 32'h4, 32'h0);
    @(posedge i_clk);
    i_sleep <= 1'b0;
    i_wdt_timeout <= 1'b1;
    @(posedge i_clk);
    i_wdt_timeout <= 1'b0;
    #1;
    `WAITFOR(o_bus_abort)
    fetch_chk(`CRS_BOOT_VA);
    rd(`CRS_OFF_CTRL, 32'h7F, CTRL_RST);
    rd(`CRS_OFF_ISTAT, 32'h4, 32'h4);
    $display("test watchdog done");
    @(posedge i_clk);
    dbg <= 1'b1;
    pin_reset(4'hC, DBG_VA);
    `CHK(o_debug_mode, 1'b1)
    rd(`CRS_OFF_DEBUG, 32'h1F, 32'h1);
    @(posedge i_clk);
    dbg <= 1'b0;
    pin_reset(4'h6, `CRS_BOOT_VA);
    `CHK(o_debug_mode, 1'b0)
    $display("test debug_boot done");
    complete_run();
  end
endmodule // cpu_core_reset_state_tb
`default_nettype wire
